// ---- indexed_postbyte_and_interrupt_entry_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module indexed_postbyte_and_interrupt_entry_tb;
   logic sys_clk_in = 0, rst_n_in = 0, quad_clk_in = 0, nmi_n_in = 1, fast_request_n_in = 1;
   logic irq_n_in = 1, dec_start_in = 0, trap_start_in = 0, pull_start_in = 0;
   logic insn_done_in = 1, wait_state_in = 0, fast_request_mask_in = 1, irq_mask_in = 1;
   logic tfr_valid_in = 0, mem_rd_out, mem_wr_out, ea_valid_out, illegal_out;
   logic base_wb_en_out, svc_valid_out, pull_valid_out, bus_state_out, busy_out, tfr_bad_out;
   logic [15:0] idx_x_in, idx_y_in, usp_in, ssp_in, pc_in, mem_addr_out, eff_addr_out;
   logic [15:0] base_wb_out, pc_next_out, svc_vec_out, sp_out, lf = 16'h6F22;
   logic [7:0] acc_a_in, acc_b_in, ccr_in, dp_in, postbyte_in = 0, tfr_post_in = 0;
   logic [7:0] mem_wdata_out, mem_rdata_in, pull_data_out;
   logic [3:0] pull_idx_out, tfr_src_out, tfr_dst_out;
   logic [2:0] svc_src_out;
   logic [1:0] trap_sel_in = 0, base_sel_out;
   logic [111:0] rv;
   int num_errors = 0, cmp_count = 0;
   // random register file seen by the core
   assign {idx_x_in, idx_y_in, usp_in, ssp_in, pc_in, acc_a_in, acc_b_in, ccr_in, dp_in} = rv;
   // system and quadrature clocks
   always #2.5 sys_clk_in = ~sys_clk_in;
   always #21 quad_clk_in = ~quad_clk_in;
   ipie_core ipie_core_inst (.sys_clk_in, .rst_n_in, .quad_clk_in, .nmi_n_in, .fast_request_n_in,
      .irq_n_in, .idx_x_in, .idx_y_in, .usp_in, .ssp_in, .pc_in, .acc_a_in, .acc_b_in,
      .ccr_in, .dp_in, .dec_start_in, .postbyte_in, .trap_start_in, .trap_sel_in,
      .pull_start_in, .insn_done_in, .wait_state_in, .fast_request_mask_in, .irq_mask_in,
      .tfr_valid_in, .tfr_post_in, .mem_addr_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out,
      .mem_rdata_in, .eff_addr_out, .ea_valid_out, .illegal_out, .base_wb_out, .base_sel_out,
      .base_wb_en_out, .pc_next_out, .svc_vec_out, .svc_valid_out, .svc_src_out, .sp_out,
      .pull_data_out, .pull_idx_out, .pull_valid_out, .bus_state_out, .busy_out,
      .tfr_src_out, .tfr_dst_out, .tfr_bad_out);
   ipie_mem_model ipie_mem_model_inst (.sys_clk_in, .mem_addr_in(mem_addr_out),
      .mem_rd_in(mem_rd_out), .mem_rdata_out(mem_rdata_in));
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nx
   function automatic logic [15:0] m16(input logic [15:0] a);
      return {a[7:0] ^ 8'h5A, (a[7:0] + 8'h01) ^ 8'h5A};
   endfunction : m16
   function automatic logic [15:0] bs(input logic [1:0] s);
      return s == 0 ? idx_x_in : s == 1 ? idx_y_in : s == 2 ? usp_in : ssp_in;
   endfunction : bs
   function automatic logic tbad(input logic [7:0] t);
      return (t[7:4] inside {[6:7], [12:15]}) || (t[3:0] inside {[6:7], [12:15]}) || t[7] != t[3];
   endfunction : tbad
   function automatic logic [16:0] ea_of(input logic [7:0] p);
      logic [15:0] b, o, r;
      logic ill;
      b = bs(p[6:5]);
      o = m16(pc_in);
      ill = 0;
      case (p[3:0])
         4'h0: {ill, r} = {p[4], b};
         4'h1, 4'h4: r = b;
         4'h2: {ill, r} = {p[4], b - 16'h0001};
         4'h3: r = b - 16'h0002;
         4'h5: r = b + {{8{acc_b_in[7]}}, acc_b_in};
         4'h6: r = b + {{8{acc_a_in[7]}}, acc_a_in};
         4'h8: r = b + {{8{o[15]}}, o[15:8]};
         4'h9: r = b + o;
         4'hB: r = b + {acc_a_in, acc_b_in};
         4'hC: r = pc_in + 16'h0001 + {{8{o[15]}}, o[15:8]};
         4'hD: r = pc_in + 16'h0002 + o;
         4'hF: {ill, r} = {p != 8'h9F, o};
         default: {ill, r} = {1'b1, b};
      endcase
      if (p[4]) r = m16(r);
      return p[7] ? {ill, r} : {1'b0, b + {{11{p[4]}}, p[4:0]}};
   endfunction : ea_of
   task automatic chk(input string n, input logic [15:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wt(input int lim);
      int i;
      i = 0;
      while (svc_valid_out !== 1'b1 && i < lim) @(negedge sys_clk_in) i++;
      if (i >= lim) num_errors++;
   endtask : wt
   task automatic dec(input logic [7:0] pb, input logic [16:0] e);
      int i;
      i = 0;
      while (busy_out !== 1'b0 && i < 300) @(negedge sys_clk_in) i++;
      if (i >= 300) num_errors++;
      @(posedge sys_clk_in) {dec_start_in, postbyte_in} <= {1'b1, pb};
      @(posedge sys_clk_in) dec_start_in <= 0;
      i = 0;
      while (ea_valid_out !== 1'b1 && illegal_out !== 1'b1 && i < 40) @(negedge sys_clk_in) i++;
      if (i >= 40) num_errors++;
      chk("illegal", illegal_out, e[16]);
      if (!e[16]) chk("ea", eff_addr_out, e[15:0]);
   endtask : dec
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // watchdog against a hang
   initial begin
      #150000;
      num_errors++;
      final_report;
   end
   // restart, decode, transfer, service entry
   initial begin
      logic [7:0] pb;
      int k;
      for (k = 0; k < 7; k++) begin
         lf = nx(lf);
         rv = {rv[95:0], lf};
      end
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1;
      wt(60);
      chk("restart vec", svc_vec_out, m16(ipie_pkg::VEC_RESTART));
      $display("test restart done");
      for (k = 0; k < 200; k++) begin
         lf = nx(lf);
         pb = k < 128 ? {1'b1, k[6:0]} : lf[7:0];
         dec(pb, ea_of(pb));
      end
      $display("test decode done");
      for (k = 0; k < 40; k++) begin
         lf = nx(lf);
         @(posedge sys_clk_in) {tfr_valid_in, tfr_post_in} <= {1'b1, lf[7:0]};
         @(posedge sys_clk_in) tfr_valid_in <= 0;
         @(negedge sys_clk_in);
         chk("tfr", {tfr_src_out, tfr_dst_out, 7'h00, tfr_bad_out},
            {lf[7:0], 7'h00, tbad(lf[7:0])});
      end
      $display("test transfer done");
      @(posedge sys_clk_in) {nmi_n_in, insn_done_in} <= 2'h0;
      repeat (20) @(posedge sys_clk_in);
      {nmi_n_in, insn_done_in} <= 2'h3;
      wt(800);
      chk("nmi src", svc_src_out, ipie_pkg::SRC_NMI);
      chk("nmi vec", svc_vec_out, m16(ipie_pkg::VEC_NMI));
      chk("sp", sp_out, ssp_in - 16'h000C);
      @(posedge sys_clk_in) {trap_start_in, trap_sel_in} <= 3'h6;
      @(posedge sys_clk_in) trap_start_in <= 0;
      wt(200);
      chk("trap", svc_vec_out, m16(ipie_pkg::VEC_TRAP2));
      $display("test nmi done");
      final_report;
   end
endmodule : indexed_postbyte_and_interrupt_entry_tb
`default_nettype wire

// ---- ipie_core.sv ----
// How it works
// - bit7 clear: base plus five-bit offset
// - accumulator offsets A, B, D added
// - auto step; step-one indirect illegal
// - counter-relative eight/sixteen bit offsets
// - extended indirect takes two following bytes
// - transfer post-byte: source high, destination low
// - vectors fetched from fixed top pairs
// - full stack order CC up to PC
// - requests sampled on quadrature falling edge
// - one sync cycle before recognition
// - service waits for instruction end or wait
// - no requests until bus-state reset acknowledge
`timescale 1ns/1ps
`default_nettype none
module ipie_core (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // interrupt pins
   input wire logic quad_clk_in,
   input wire logic nmi_n_in,
   input wire logic fast_request_n_in,
   input wire logic irq_n_in,
   // core register values
   input wire logic [15:0] idx_x_in,
   input wire logic [15:0] idx_y_in,
   input wire logic [15:0] usp_in,
   input wire logic [15:0] ssp_in,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] acc_a_in,
   input wire logic [7:0] acc_b_in,
   input wire logic [7:0] ccr_in,
   input wire logic [7:0] dp_in,
   // core control
   input wire logic dec_start_in,
   input wire logic [7:0] postbyte_in,
   input wire logic trap_start_in,
   input wire logic [1:0] trap_sel_in,
   input wire logic pull_start_in,
   input wire logic insn_done_in,
   input wire logic wait_state_in,
   input wire logic fast_request_mask_in,
   input wire logic irq_mask_in,
   input wire logic tfr_valid_in,
   input wire logic [7:0] tfr_post_in,
   // memory bus
   output logic [15:0] mem_addr_out,
   output logic mem_rd_out,
   output logic mem_wr_out,
   output logic [7:0] mem_wdata_out,
   input wire logic [7:0] mem_rdata_in,
   // address results
   output logic [15:0] eff_addr_out,
   output logic ea_valid_out,
   output logic illegal_out,
   output logic [15:0] base_wb_out,
   output logic [1:0] base_sel_out,
   output logic base_wb_en_out,
   output logic [15:0] pc_next_out,
   // service and stack results
   output logic [15:0] svc_vec_out,
   output logic svc_valid_out,
   output logic [2:0] svc_src_out,
   output logic [15:0] sp_out,
   output logic [7:0] pull_data_out,
   output logic [3:0] pull_idx_out,
   output logic pull_valid_out,
   output logic bus_state_out,
   output logic busy_out,
   // transfer decode
   output logic [3:0] tfr_src_out,
   output logic [3:0] tfr_dst_out,
   output logic tfr_bad_out
);
   typedef enum logic [2:0] {ST_RVEC, ST_IDLE, ST_OPND, ST_CALC, ST_IND, ST_PUSH, ST_VEC,
      ST_PULL} ipie_state_t;

   ipie_state_t st_r;
   logic [1:0] ph_r;
   logic [3:0] cnt_r;
   logic [15:0] addr_r, dat_r, vec_r;
   logic [7:0] pb_r, push_byte;
   logic fast_r, gate_r, rdstep, reading, ind, bad, wb_en, allow;
   logic take_nmi, take_fast_request, take_irq;
   logic [15:0] base_w, ea_nxt, wb_nxt;
   logic [1:0] nb;

   ipie_irq_if irq ();

   ipie_irq_sync u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .quad_clk_in(quad_clk_in),
      .nmi_n_in(nmi_n_in),
      .fast_request_n_in(fast_request_n_in),
      .irq_n_in(irq_n_in),
      .irq(irq)
   );

   // operand bytes that follow a post-byte
   function automatic logic [1:0] opnd_bytes(input logic [7:0] pb);
      opnd_bytes = 2'h0;
      if (pb[ipie_pkg::PB_MODE_BIT]) begin
         case (pb[3:0])
            ipie_pkg::LO_OFF8, ipie_pkg::LO_PC8: opnd_bytes = 2'h1;
            ipie_pkg::LO_OFF16, ipie_pkg::LO_PC16, ipie_pkg::LO_EXT: opnd_bytes = 2'h2;
            default: opnd_bytes = 2'h0;
         endcase
      end
   endfunction : opnd_bytes

   // defined transfer register code
   function automatic logic tx_ok(input logic [3:0] c);
      tx_ok = (c <= ipie_pkg::TX_PC) || (c >= ipie_pkg::TX_A && c <= ipie_pkg::TX_DP);
   endfunction : tx_ok

   assign nb = opnd_bytes(postbyte_in);
   assign rdstep = (ph_r == 2'h2);
   assign reading = (st_r == ST_RVEC) || (st_r == ST_OPND) || (st_r == ST_IND) ||
      (st_r == ST_VEC) || (st_r == ST_PULL);
   assign ind = pb_r[ipie_pkg::PB_MODE_BIT] & pb_r[ipie_pkg::PB_IND_BIT];

   // service entry only at instruction end or while waiting
   assign allow = (st_r == ST_IDLE) && gate_r && (insn_done_in || wait_state_in);
   assign take_nmi = allow && irq.nmi_pend;
   assign take_fast_request = allow && !irq.nmi_pend && irq.fast_request_pend && !fast_request_mask_in;
   assign take_irq = allow && !irq.nmi_pend && !take_fast_request && irq.irq_pend && !irq_mask_in;
   assign irq.nmi_take = take_nmi;
   assign irq.gate_open = gate_r;

   // base register from the select field
   always_comb begin
      case (pb_r[ipie_pkg::PB_SEL_LSB +: 2])
         ipie_pkg::SEL_X: base_w = idx_x_in;
         ipie_pkg::SEL_Y: base_w = idx_y_in;
         ipie_pkg::SEL_U: base_w = usp_in;
         default: base_w = ssp_in;
      endcase
   end

   // address arithmetic; addr_r already points past the operands
   always_comb begin
      ea_nxt = base_w;
      wb_nxt = base_w;
      wb_en = 1'b0;
      bad = 1'b0;
      if (!pb_r[ipie_pkg::PB_MODE_BIT]) begin
         ea_nxt = base_w + {{11{pb_r[4]}}, pb_r[4:0]};
      end else begin
         case (pb_r[3:0])
            ipie_pkg::LO_INC1: begin
               wb_nxt = base_w + 16'h0001;
               wb_en = 1'b1;
               bad = ind;
            end
            ipie_pkg::LO_INC2: begin
               wb_nxt = base_w + 16'h0002;
               wb_en = 1'b1;
            end
            ipie_pkg::LO_DEC1: begin
               ea_nxt = base_w - 16'h0001;
               wb_nxt = ea_nxt;
               wb_en = 1'b1;
               bad = ind;
            end
            ipie_pkg::LO_DEC2: begin
               ea_nxt = base_w - 16'h0002;
               wb_nxt = ea_nxt;
               wb_en = 1'b1;
            end
            ipie_pkg::LO_ZERO: ea_nxt = base_w;
            ipie_pkg::LO_ACCB: ea_nxt = base_w + {{8{acc_b_in[7]}}, acc_b_in};
            ipie_pkg::LO_ACCA: ea_nxt = base_w + {{8{acc_a_in[7]}}, acc_a_in};
            ipie_pkg::LO_ACCD: ea_nxt = base_w + {acc_a_in, acc_b_in};
            ipie_pkg::LO_OFF8: ea_nxt = base_w + {{8{dat_r[7]}}, dat_r[7:0]};
            ipie_pkg::LO_OFF16: ea_nxt = base_w + dat_r;
            ipie_pkg::LO_PC8: ea_nxt = addr_r + {{8{dat_r[7]}}, dat_r[7:0]};
            ipie_pkg::LO_PC16: ea_nxt = addr_r + dat_r;
            ipie_pkg::LO_EXT: begin
               ea_nxt = dat_r;
               bad = (pb_r != ipie_pkg::EXT_IND_PB);
            end
            default: bad = 1'b1;
         endcase
      end
   end

   // byte placed at each stack slot, lowest address first
   always_comb begin
      case (cnt_r)
         ipie_pkg::SI_CC: push_byte = ccr_in;
         ipie_pkg::SI_A: push_byte = acc_a_in;
         ipie_pkg::SI_B: push_byte = acc_b_in;
         ipie_pkg::SI_DP: push_byte = dp_in;
         ipie_pkg::SI_XH: push_byte = idx_x_in[15:8];
         ipie_pkg::SI_XL: push_byte = idx_x_in[7:0];
         ipie_pkg::SI_YH: push_byte = idx_y_in[15:8];
         ipie_pkg::SI_YL: push_byte = idx_y_in[7:0];
         ipie_pkg::SI_OH: push_byte = usp_in[15:8];
         ipie_pkg::SI_OL: push_byte = usp_in[7:0];
         ipie_pkg::SI_PCH: push_byte = pc_in[15:8];
         default: push_byte = pc_in[7:0];
      endcase
   end

   // read phase: issue, wait, capture
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ph_r <= 2'h0;
         dat_r <= 16'h0000;
      end else begin
         ph_r <= (reading && !rdstep) ? ph_r + 2'h1 : 2'h0;
         if (rdstep) begin
            dat_r <= {dat_r[7:0], mem_rdata_in};
         end
      end
   end

   // sequencer
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= ST_RVEC;
         cnt_r <= 4'h0;
         addr_r <= ipie_pkg::VEC_RESTART;
         pb_r <= 8'h00;
         vec_r <= ipie_pkg::VEC_RSVD;
         fast_r <= 1'b0;
      end else begin
         if (rdstep) begin
            addr_r <= addr_r + 16'h0001;
            cnt_r <= cnt_r + 4'h1;
         end
         case (st_r)
            ST_RVEC: if (rdstep && cnt_r == 4'h1) st_r <= ST_IDLE;
            ST_IDLE: begin
               cnt_r <= 4'h0;
               if (take_nmi || take_fast_request || take_irq) begin
                  st_r <= ST_PUSH;
                  cnt_r <= ipie_pkg::SI_PCL;
                  addr_r <= ssp_in;
                  fast_r <= take_fast_request;
                  vec_r <= take_nmi ? ipie_pkg::VEC_NMI :
                     take_fast_request ? ipie_pkg::VEC_FAST_REQUEST : ipie_pkg::VEC_IRQ;
               end else if (dec_start_in) begin
                  pb_r <= postbyte_in;
                  addr_r <= pc_in;
                  st_r <= (nb != 2'h0) ? ST_OPND : ST_CALC;
               end else if (trap_start_in) begin
                  st_r <= ST_PUSH;
                  cnt_r <= ipie_pkg::SI_PCL;
                  addr_r <= ssp_in;
                  fast_r <= 1'b0;
                  vec_r <= (trap_sel_in == 2'h2) ? ipie_pkg::VEC_TRAP2 :
                     (trap_sel_in == 2'h3) ? ipie_pkg::VEC_TRAP3 : ipie_pkg::VEC_TRAP1;
               end else if (pull_start_in) begin
                  st_r <= ST_PULL;
                  addr_r <= ssp_in;
               end
            end
            ST_OPND: if (rdstep && cnt_r + 4'h1 == {2'h0, opnd_bytes(pb_r)}) st_r <= ST_CALC;
            ST_CALC: begin
               cnt_r <= 4'h0;
               addr_r <= ea_nxt;
               st_r <= (!bad && ind) ? ST_IND : ST_IDLE;
            end
            ST_IND: if (rdstep && cnt_r == 4'h1) st_r <= ST_IDLE;
            ST_PUSH: begin
               if (cnt_r == ipie_pkg::SI_CC) begin
                  st_r <= ST_VEC;
                  addr_r <= vec_r;
               end else begin
                  addr_r <= addr_r - 16'h0001;
                  // fast request stacks only counter and flags
                  cnt_r <= (fast_r && cnt_r == ipie_pkg::SI_PCH) ? ipie_pkg::SI_CC :
                     cnt_r - 4'h1;
               end
            end
            ST_VEC: if (rdstep && cnt_r == 4'h1) st_r <= ST_IDLE;
            ST_PULL: if (rdstep && cnt_r == ipie_pkg::SI_PCL) st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // memory bus drive
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_addr_out <= 16'h0000;
         mem_rd_out <= 1'b0;
         mem_wr_out <= 1'b0;
         mem_wdata_out <= 8'h00;
      end else begin
         mem_rd_out <= reading && ph_r == 2'h0;
         mem_wr_out <= (st_r == ST_PUSH);
         mem_wdata_out <= push_byte;
         mem_addr_out <= (st_r == ST_PUSH) ? addr_r - 16'h0001 : addr_r;
      end
   end

   // address results
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         eff_addr_out <= 16'h0000;
         ea_valid_out <= 1'b0;
         illegal_out <= 1'b0;
         base_wb_out <= 16'h0000;
         base_sel_out <= 2'h0;
         base_wb_en_out <= 1'b0;
         pc_next_out <= 16'h0000;
      end else begin
         ea_valid_out <= (st_r == ST_CALC && !bad && !ind) ||
            (st_r == ST_IND && rdstep && cnt_r == 4'h1);
         illegal_out <= (st_r == ST_CALC) && bad;
         base_wb_en_out <= (st_r == ST_CALC) && !bad && wb_en;
         if (st_r == ST_CALC) begin
            eff_addr_out <= ea_nxt;
            base_wb_out <= wb_nxt;
            base_sel_out <= pb_r[ipie_pkg::PB_SEL_LSB +: 2];
            pc_next_out <= addr_r;
         end else if (st_r == ST_IND && rdstep && cnt_r == 4'h1) begin
            eff_addr_out <= {dat_r[7:0], mem_rdata_in};
         end
      end
   end

   // service, stack and reset acknowledge results
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         svc_vec_out <= 16'h0000;
         svc_valid_out <= 1'b0;
         svc_src_out <= 3'h0;
         sp_out <= 16'h0000;
         pull_data_out <= 8'h00;
         pull_idx_out <= 4'h0;
         pull_valid_out <= 1'b0;
         bus_state_out <= 1'b0;
         gate_r <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         svc_valid_out <= (st_r == ST_VEC || st_r == ST_RVEC) && rdstep && cnt_r == 4'h1;
         if (rdstep && cnt_r == 4'h1) begin
            svc_vec_out <= {dat_r[7:0], mem_rdata_in};
         end
         if (take_nmi) svc_src_out <= ipie_pkg::SRC_NMI;
         else if (take_fast_request) svc_src_out <= ipie_pkg::SRC_FAST_REQUEST;
         else if (take_irq) svc_src_out <= ipie_pkg::SRC_IRQ;
         else if (st_r == ST_IDLE && trap_start_in) svc_src_out <= ipie_pkg::SRC_TRAP;
         if (st_r == ST_PUSH && cnt_r == ipie_pkg::SI_CC) sp_out <= addr_r - 16'h0001;
         if (st_r == ST_PULL && rdstep && cnt_r == ipie_pkg::SI_PCL) sp_out <= addr_r + 16'h0001;
         pull_valid_out <= (st_r == ST_PULL) && rdstep;
         if (rdstep) begin
            pull_data_out <= mem_rdata_in;
            pull_idx_out <= cnt_r;
         end
         bus_state_out <= (st_r == ST_RVEC);
         gate_r <= gate_r | bus_state_out;
         busy_out <= (st_r != ST_IDLE);
      end
   end

   // transfer/exchange post-byte split
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tfr_src_out <= ipie_pkg::TX_D;
         tfr_dst_out <= ipie_pkg::TX_D;
         tfr_bad_out <= 1'b0;
      end else if (tfr_valid_in) begin
         tfr_src_out <= tfr_post_in[7:4];
         tfr_dst_out <= tfr_post_in[3:0];
         tfr_bad_out <= !tx_ok(tfr_post_in[7:4]) || !tx_ok(tfr_post_in[3:0]) ||
            (tfr_post_in[7] != tfr_post_in[3]);
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence s_ind_hi;
      st_r == ST_IND && rdstep && cnt_r == 4'h0;
   endsequence
   sequence s_ind_lo;
      st_r == ST_IND && rdstep && cnt_r == 4'h1;
   endsequence

   restart_vec_a: assert property ($rose(mem_rd_out) && bus_state_out |->
      mem_addr_out == ipie_pkg::VEC_RESTART || mem_addr_out == ipie_pkg::VEC_RESTART + 16'h0001)
      else $error("restart vector read from wrong address");
   five_bit_a: assert property (st_r == ST_CALC && !pb_r[7] |=> ea_valid_out &&
      eff_addr_out == $past(base_w) + {{11{$past(pb_r[4])}}, $past(pb_r[4:0])})
      else $error("five-bit offset address wrong");
   acc_d_a: assert property (st_r == ST_CALC && pb_r[7:4] ==? 4'b1??0 &&
      pb_r[3:0] == ipie_pkg::LO_ACCD |=> eff_addr_out == $past(base_w) +
      {$past(acc_a_in), $past(acc_b_in)})
      else $error("double accumulator offset wrong");
   step_one_ind_a: assert property (st_r == ST_CALC && ind && pb_r[3:1] == 3'h0 &&
      !pb_r[0] |=> illegal_out && !ea_valid_out)
      else $error("illegal indirect step not flagged");
   pc_rel_a: assert property (st_r == ST_CALC && pb_r[7] && !pb_r[4] &&
      pb_r[3:0] == ipie_pkg::LO_PC8 |=> eff_addr_out == $past(addr_r) +
      {{8{$past(dat_r[7])}}, $past(dat_r[7:0])})
      else $error("counter-relative address wrong");
   ind_read_a: assert property (s_ind_hi ##3 s_ind_lo |=> ea_valid_out &&
      eff_addr_out == {$past(mem_rdata_in, 4), $past(mem_rdata_in)})
      else $error("indirect pointer not high byte first");
   push_first_a: assert property (st_r == ST_PUSH && cnt_r == ipie_pkg::SI_PCL |=>
      mem_wr_out && mem_addr_out == $past(addr_r) - 16'h0001 &&
      mem_wdata_out == $past(pc_in[7:0]))
      else $error("stacking does not start with counter low byte");
   defer_a: assert property (st_r == ST_IDLE && !insn_done_in && !wait_state_in &&
      !trap_start_in |=> st_r != ST_PUSH)
      else $error("service began mid-instruction");
   gate_open_a: assert property (!bus_state_out && !gate_r |=> !gate_r)
      else $error("requests enabled before reset acknowledge");
endmodule : ipie_core
`default_nettype wire

// ---- ipie_irq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface ipie_irq_if;
   logic nmi_pend;
   logic fast_request_pend;
   logic irq_pend;
   logic nmi_take;
   logic gate_open;
   modport sync (output nmi_pend, output fast_request_pend, output irq_pend,
      input nmi_take, input gate_open);
   modport core (input nmi_pend, input fast_request_pend, input irq_pend,
      output nmi_take, output gate_open);
endinterface : ipie_irq_if
`default_nettype wire

// ---- ipie_irq_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ipie_irq_sync (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // pins: quadrature clock and active-low requests
   input wire logic quad_clk_in,
   input wire logic nmi_n_in,
   input wire logic fast_request_n_in,
   input wire logic irq_n_in,
   // towards the core
   ipie_irq_if.sync irq
);
   logic [3:0] s1_r, s2_r, s3_r, stab_r;
   logic q_prev_r;
   logic [2:0] samp_r, rec_r;
   logic nmi_lat_r;
   logic q_fall;

   // three-stage synchroniser; s1 feeds s2 only
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_r <= 4'hF;
         s2_r <= 4'hF;
         s3_r <= 4'hF;
      end else begin
         s1_r <= {quad_clk_in, nmi_n_in, fast_request_n_in, irq_n_in};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // a pin change counts once stages two and three agree
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stab_r <= 4'hF;
         q_prev_r <= 1'b1;
      end else begin
         stab_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & stab_r);
         q_prev_r <= stab_r[3];
      end
   end

   assign q_fall = q_prev_r & ~stab_r[3];

   // sample on quadrature fall, recognise one fall later
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         samp_r <= 3'h0;
         rec_r <= 3'h0;
      end else if (!irq.gate_open) begin
         samp_r <= 3'h0;
         rec_r <= 3'h0;
      end else if (q_fall) begin
         samp_r <= ~stab_r[2:0];
         rec_r <= samp_r;
      end
   end

   // nonmaskable request latched on its recognised edge; set beats take
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         nmi_lat_r <= 1'b0;
      end else if (!irq.gate_open) begin
         nmi_lat_r <= 1'b0;
      end else if (q_fall && samp_r[2] && !rec_r[2]) begin
         nmi_lat_r <= 1'b1;
      end else if (irq.nmi_take) begin
         nmi_lat_r <= 1'b0;
      end
   end

   assign irq.nmi_pend = nmi_lat_r;
   assign irq.fast_request_pend = rec_r[1];
   assign irq.irq_pend = rec_r[0];

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   samp_on_fall_a: assert property (!q_fall |=> $stable(samp_r))
      else $error("requests sampled off the quadrature fall");
   sync_delay_a: assert property (q_fall && irq.gate_open |=> rec_r == $past(samp_r))
      else $error("recognition skipped the sync cycle");
   gate_closed_a: assert property (!irq.gate_open |=> rec_r == 3'h0 && !nmi_lat_r)
      else $error("request latched before reset acknowledge");
endmodule : ipie_irq_sync
`default_nettype wire

// ---- ipie_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ipie_mem_model (
   // memory bus from the core
   input wire logic sys_clk_in,
   input wire logic [15:0] mem_addr_in,
   input wire logic mem_rd_in,
   output logic [7:0] mem_rdata_out
);
   initial mem_rdata_out = 8'h00;
   // byte stands the cycle after the strobe only, then flips
   always @(posedge sys_clk_in) begin
      if (mem_rd_in) mem_rdata_out <= mem_addr_in[7:0] ^ 8'h5A;
      else mem_rdata_out <= ~mem_rdata_out;
   end
endmodule : ipie_mem_model
`default_nettype wire

// ---- ipie_pkg.sv ----
package ipie_pkg;
   // service vector pairs at the top of memory
   localparam logic [15:0] VEC_RESTART = 16'hFFFE;
   localparam logic [15:0] VEC_NMI = 16'hFFFC;
   localparam logic [15:0] VEC_TRAP1 = 16'hFFFA;
   localparam logic [15:0] VEC_IRQ = 16'hFFF8;
   localparam logic [15:0] VEC_FAST_REQUEST = 16'hFFF6;
   localparam logic [15:0] VEC_TRAP2 = 16'hFFF4;
   localparam logic [15:0] VEC_TRAP3 = 16'hFFF2;
   localparam logic [15:0] VEC_RSVD = 16'hFFF0;
   // post-byte field positions
   localparam int PB_MODE_BIT = 7;
   localparam int PB_IND_BIT = 4;
   localparam int PB_SEL_LSB = 5;
   // base_select_field codes
   localparam logic [1:0] SEL_X = 2'h0;
   localparam logic [1:0] SEL_Y = 2'h1;
   localparam logic [1:0] SEL_U = 2'h2;
   localparam logic [1:0] SEL_S = 2'h3;
   // low field of an indexed post-byte with bit 7 set
   localparam logic [3:0] LO_INC1 = 4'h0;
   localparam logic [3:0] LO_INC2 = 4'h1;
   localparam logic [3:0] LO_DEC1 = 4'h2;
   localparam logic [3:0] LO_DEC2 = 4'h3;
   localparam logic [3:0] LO_ZERO = 4'h4;
   localparam logic [3:0] LO_ACCB = 4'h5;
   localparam logic [3:0] LO_ACCA = 4'h6;
   localparam logic [3:0] LO_OFF8 = 4'h8;
   localparam logic [3:0] LO_OFF16 = 4'h9;
   localparam logic [3:0] LO_ACCD = 4'hB;
   localparam logic [3:0] LO_PC8 = 4'hC;
   localparam logic [3:0] LO_PC16 = 4'hD;
   localparam logic [3:0] LO_EXT = 4'hF;
   localparam logic [7:0] EXT_IND_PB = 8'h9F;
   // transfer/exchange register codes
   localparam logic [3:0] TX_D = 4'h0;
   localparam logic [3:0] TX_PC = 4'h5;
   localparam logic [3:0] TX_A = 4'h8;
   localparam logic [3:0] TX_DP = 4'hB;
   // stacked byte index, lowest address first
   localparam logic [3:0] SI_CC = 4'h0;
   localparam logic [3:0] SI_A = 4'h1;
   localparam logic [3:0] SI_B = 4'h2;
   localparam logic [3:0] SI_DP = 4'h3;
   localparam logic [3:0] SI_XH = 4'h4;
   localparam logic [3:0] SI_XL = 4'h5;
   localparam logic [3:0] SI_YH = 4'h6;
   localparam logic [3:0] SI_YL = 4'h7;
   localparam logic [3:0] SI_OH = 4'h8;
   localparam logic [3:0] SI_OL = 4'h9;
   localparam logic [3:0] SI_PCH = 4'hA;
   localparam logic [3:0] SI_PCL = 4'hB;
   // service source codes
   localparam logic [2:0] SRC_NMI = 3'h1;
   localparam logic [2:0] SRC_FAST_REQUEST = 3'h2;
   localparam logic [2:0] SRC_IRQ = 3'h3;
   localparam logic [2:0] SRC_TRAP = 3'h4;
endpackage : ipie_pkg
